// ==== shared/sss_pkg.sv ====
// Purpose: shared types and constants of the subtract/swap/skip execute slice
// Assumes: 8-bit data path, one instruction cycle per clk_sys edge
// Notes: opcodes and phases are one-hot
package sss_pkg;
	// data path shape
	localparam int DATA_W = 8;
	localparam int NIB_W = 4;
	// reset and compare values
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [7:0] MEM_WDATA_RST = 8'h00;
	// instruction cycle counts
	localparam int SKIP_CYCLES = 2;
	localparam int PLAIN_CYCLES = 1;

	// operation select, one-hot
	typedef enum logic [6:0] {
		op_none = 7'h01,
		skip_if_nonzero_op = 7'h02,
		minus_to_working_op = 7'h04,
		minus_to_memory_op = 7'h08,
		minus_immediate_op = 7'h10,
		nibble_exchange_op = 7'h20,
		nibble_exchange_to_working_op = 7'h40
	} sss_op_type;

	// sequencing phase, one-hot
	typedef enum logic [1:0] {
		ph_run = 2'h1,
		ph_dummy = 2'h2
	} sss_phase_type;

	// status flags touched by subtraction
	typedef struct packed {
		logic signed_range_flag;
		logic zero_flag;
		logic half_carry_flag;
		logic carry_flag;
		logic extended_sign_flag;
		logic extended_zero_flag;
	} sss_flags_type;

	localparam sss_flags_type FLAGS_RST = '0;

	// one issued instruction
	typedef struct packed {
		logic issue;
		sss_op_type op;
		logic [7:0] mem_data;
		logic [7:0] imm;
	} sss_req_type;

	// data memory write-back
	typedef struct packed {
		logic we;
		logic [7:0] wdata;
	} sss_mem_wr_type;

	// whole state of the execute slice
	typedef struct packed {
		sss_phase_type phase;
		logic [7:0] acc;
		sss_flags_type flags;
		sss_mem_wr_type mem_wr;
		logic done;
		logic skip;
		logic ready;
	} sss_state_type;
endpackage

// ==== src/sss_exec.sv ====
// Purpose: executes skip-if-nonzero, subtract and nibble-exchange instructions
// Assumes: fetch logic supplies the addressed byte and immediate with issue
// Notes: results, flags and write-back appear one edge after issue
`timescale 1ns/1ps

module sss_exec
	import sss_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// instruction issue
	input wire sss_req_type req,
	// accumulator load by other instructions
	input wire logic acc_load,
	input wire logic [DATA_W-1:0] acc_load_data,
	// results
	output logic [DATA_W-1:0] acc,
	output sss_flags_type flags,
	output sss_mem_wr_type mem_wr,
	// sequencing
	output logic done,
	output logic skip,
	output logic ready
);

	////////////////////////////////////////////////////////////////////////
	// state
	sss_state_type st_r; // all registered state
	sss_state_type st_nxt; // next value of it
	logic take; // issue accepted this cycle
	logic [DATA_W-1:0] sub_b; // subtrahend
	logic [DATA_W:0] diff; // ninth bit is the borrow
	logic [NIB_W:0] nib_diff; // low nibble borrow
	logic [DATA_W-1:0] res; // difference
	logic [DATA_W-1:0] swapped; // nibble-exchanged byte
	sss_flags_type sub_flags; // flags of the difference

	////////////////////////////////////////////////////////////////////////
	// arithmetic
	always_comb begin
		// immediate or memory byte
		sub_b = (req.op == minus_immediate_op) ? req.imm : req.mem_data;
		diff = {1'b0, st_r.acc} - {1'b0, sub_b};
		nib_diff = {1'b0, st_r.acc[NIB_W-1:0]} - {1'b0, sub_b[NIB_W-1:0]};
		res = diff[DATA_W-1:0];
		swapped = {req.mem_data[NIB_W-1:0], req.mem_data[DATA_W-1:NIB_W]};
		// borrow out means negative: carry cleared
		sub_flags.carry_flag = ~diff[DATA_W];
		sub_flags.half_carry_flag = ~nib_diff[NIB_W];
		sub_flags.zero_flag = (res == ZERO_BYTE);
		// signs differ and result sign leaves the minuend
		sub_flags.signed_range_flag = (st_r.acc[DATA_W-1] != sub_b[DATA_W-1])
			&& (res[DATA_W-1] != st_r.acc[DATA_W-1]);
		// true sign of the wide result
		sub_flags.extended_sign_flag = sub_flags.signed_range_flag ^ res[DATA_W-1];
		// no carry-in here, so it tracks zero
		sub_flags.extended_zero_flag = sub_flags.zero_flag;
	end

	////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		st_nxt = st_r;
		// pulses fall back every cycle
		st_nxt.done = 1'b0;
		st_nxt.skip = 1'b0;
		st_nxt.mem_wr.we = 1'b0;
		take = 1'b0;
		unique case (st_r.phase)
			ph_run: begin
				take = req.issue;
				// outside load only in ph_run with no issue, even for ops that leave acc alone
				if (acc_load && !req.issue) begin
					st_nxt.acc = acc_load_data;
				end
				if (take) begin
					// every accepted op except op_none and illegal codes reports one edge later
					st_nxt.done = 1'b1;
					unique case (req.op)
						skip_if_nonzero_op: begin
							// nonzero byte skips and costs a dummy
							if (req.mem_data != ZERO_BYTE) begin
								st_nxt.skip = 1'b1;
								st_nxt.phase = ph_dummy;
								st_nxt.ready = 1'b0;
							end
						end
						minus_to_working_op: begin
							st_nxt.acc = res;
							st_nxt.flags = sub_flags;
						end
						minus_to_memory_op: begin
							// accumulator left as is
							st_nxt.mem_wr.we = 1'b1;
							st_nxt.mem_wr.wdata = res;
							st_nxt.flags = sub_flags;
						end
						minus_immediate_op: begin
							st_nxt.acc = res;
							st_nxt.flags = sub_flags;
						end
						nibble_exchange_op: begin
							// flags deliberately untouched
							st_nxt.mem_wr.we = 1'b1;
							st_nxt.mem_wr.wdata = swapped;
						end
						nibble_exchange_to_working_op: begin
							// no write-back, memory keeps its value
							st_nxt.acc = swapped;
						end
						op_none: begin
							st_nxt.done = 1'b0;
						end
						default: begin
							// illegal code: treated as no-op
							st_nxt.done = 1'b0;
						end
					endcase
				end
			end
			ph_dummy: begin
				// dummy cycle: the skipped fetch is discarded
				st_nxt.phase = ph_run;
				st_nxt.ready = 1'b1;
			end
			default: begin
				st_nxt.phase = ph_run;
				st_nxt.ready = 1'b1;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st_r.phase <= ph_run;
			st_r.acc <= ACC_RST;
			st_r.flags <= FLAGS_RST;
			st_r.mem_wr.we <= 1'b0;
			st_r.mem_wr.wdata <= MEM_WDATA_RST;
			st_r.done <= 1'b0;
			st_r.skip <= 1'b0;
			st_r.ready <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// outputs straight from flops
	assign acc = st_r.acc;
	assign flags = st_r.flags;
	assign mem_wr = st_r.mem_wr;
	assign done = st_r.done;
	assign skip = st_r.skip;
	assign ready = st_r.ready;

	////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_snz_nonzero;
		take && req.op == skip_if_nonzero_op && req.mem_data != ZERO_BYTE;
	endsequence

	sequence s_skip_dummy;
		skip && !ready ##1 ready && !skip;
	endsequence

	property p_skip_taken;
		@(posedge clk_sys) disable iff (rst)
		s_snz_nonzero |=> skip && done;
	endproperty
	a_skip_taken: assert property (p_skip_taken) else $error("nonzero byte did not skip");

	property p_no_skip_zero;
		@(posedge clk_sys) disable iff (rst)
		take && req.op == skip_if_nonzero_op && req.mem_data == ZERO_BYTE |=> !skip && ready;
	endproperty
	a_no_skip_zero: assert property (p_no_skip_zero) else $error("zero byte skipped");

	property p_dummy_cycle;
		@(posedge clk_sys) disable iff (rst)
		s_snz_nonzero |=> s_skip_dummy;
	endproperty
	a_dummy_cycle: assert property (p_dummy_cycle) else $error("skip not two cycles");

	property p_sub_acc;
		@(posedge clk_sys) disable iff (rst)
		take && req.op == minus_to_working_op
		|=> acc == DATA_W'($past(st_r.acc) - $past(req.mem_data));
	endproperty
	a_sub_acc: assert property (p_sub_acc) else $error("acc minus byte wrong");

	property p_carry;
		@(posedge clk_sys) disable iff (rst)
		take && (req.op == minus_to_working_op || req.op == minus_immediate_op
			|| req.op == minus_to_memory_op)
		|=> flags.carry_flag == ($past(st_r.acc) >= $past(sub_b));
	endproperty
	a_carry: assert property (p_carry) else $error("carry polarity wrong");

	property p_flags_kept;
		@(posedge clk_sys) disable iff (rst)
		take && (req.op == nibble_exchange_op || req.op == skip_if_nonzero_op
			|| req.op == nibble_exchange_to_working_op) |=> $stable(flags);
	endproperty
	a_flags_kept: assert property (p_flags_kept) else $error("flags changed");

	property p_sub_mem;
		@(posedge clk_sys) disable iff (rst)
		take && req.op == minus_to_memory_op |=> mem_wr.we && $stable(acc)
			&& mem_wr.wdata == DATA_W'($past(st_r.acc) - $past(req.mem_data))
			&& flags.zero_flag == (mem_wr.wdata == ZERO_BYTE);
	endproperty
	a_sub_mem: assert property (p_sub_mem) else $error("memory difference wrong");

	property p_sub_imm;
		@(posedge clk_sys) disable iff (rst)
		take && req.op == minus_immediate_op
		|=> acc == DATA_W'($past(st_r.acc) - $past(req.imm)) && !mem_wr.we;
	endproperty
	a_sub_imm: assert property (p_sub_imm) else $error("immediate subtract wrong");

	property p_swap_mem;
		@(posedge clk_sys) disable iff (rst)
		take && req.op == nibble_exchange_op |=> mem_wr.we
			&& mem_wr.wdata == {$past(req.mem_data[3:0]), $past(req.mem_data[7:4])};
	endproperty
	a_swap_mem: assert property (p_swap_mem) else $error("in-place swap wrong");

	property p_swap_acc;
		@(posedge clk_sys) disable iff (rst)
		take && req.op == nibble_exchange_to_working_op |=> !mem_wr.we
			&& acc == {$past(req.mem_data[3:0]), $past(req.mem_data[7:4])};
	endproperty
	a_swap_acc: assert property (p_swap_acc) else $error("swap to acc wrong");

	property p_single_cycle;
		@(posedge clk_sys) disable iff (rst)
		take && (req.op == minus_to_working_op || req.op == minus_to_memory_op
			|| req.op == minus_immediate_op || req.op == nibble_exchange_op
			|| req.op == nibble_exchange_to_working_op) |=> done && ready;
	endproperty
	a_single_cycle: assert property (p_single_cycle) else $error("not single cycle");

	// no-op and illegal codes must leave every result alone
	property p_noop_quiet;
		@(posedge clk_sys) disable iff (rst)
		take && (req.op == op_none || !$onehot(req.op))
		|=> !done && !mem_wr.we && $stable(flags) && $stable(acc);
	endproperty
	a_noop_quiet: assert property (p_noop_quiet) else $error("no-op changed state");

endmodule

// ==== tb/sss_exec_tb_top.sv ====
// Purpose: self-checking bench for the subtract/swap/skip execute slice
// Assumes: results show half a cycle after the taking edge, ready low in dummy
// Notes: driver notes each expected result, monitor pops one per done
`timescale 1ns/1ps
module sss_exec_tb_top
	import sss_pkg::*;
;
	// expected result with the cycle it is due in
	typedef struct packed {
		logic [7:0] a;
		sss_flags_type f;
		sss_mem_wr_type w;
		logic s;
		logic [31:0] due;
	} sss_note_type;
	// clock, reset and design inputs
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	sss_req_type req = '0;
	logic acc_load = 1'b0;
	logic [7:0] acc_load_data = 8'h00;
	// design outputs
	logic [7:0] acc;
	sss_flags_type flags;
	sss_mem_wr_type mem_wr;
	logic done, skip, ready;
	// bookkeeping
	int num_errors = 0;
	int total_checks = 0;
	int seed = 56;
	logic [31:0] cyc = '0;
	sss_note_type q[$];
	sss_note_type m_n = '0; // model state
	bit dummy_nxt = 1'b0; // next issue falls in a dummy cycle
	sss_op_type ops[7] = '{op_none, skip_if_nonzero_op, minus_to_working_op,
		minus_to_memory_op, minus_immediate_op, nibble_exchange_op,
		nibble_exchange_to_working_op};
	// borrow, zero, overflow, half-borrow and wrap corners
	logic [7:0] pa[5] = '{8'h00, 8'h05, 8'h80, 8'h10, 8'h7f};
	logic [7:0] pb[5] = '{8'h01, 8'h05, 8'h01, 8'h01, 8'hff};

	sss_exec u_sss_exec (.clk_sys(clk_sys), .rst(rst), .req(req), .acc_load(acc_load),
		.acc_load_data(acc_load_data), .acc(acc), .flags(flags), .mem_wr(mem_wr),
		.done(done), .skip(skip), .ready(ready));

	////////////////////////////////////////////////////////////////////////////////
	// clock and cycle count; the ceiling cuts a hang short
	initial forever #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 32'd20000) begin
			num_errors++;
			wrap_up();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// compare tasks and closing report
	task automatic cmp_note(input sss_note_type e, input sss_note_type g);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic cmp_bit(input logic g, input logic e);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// driver: issue one op, with a competing load that must lose
	task automatic send(input sss_op_type op, input logic [7:0] m, input logic [7:0] x);
		logic [7:0] b;
		logic [7:0] d;
		logic ov;
		@(posedge clk_sys);
		req <= '{1'b1, op, m, x};
		acc_load <= 1'b1;
		acc_load_data <= ~m_n.a;
		// refused in the dummy cycle, or no-op: nothing expected
		if (dummy_nxt || op == op_none || !$onehot(op)) begin
			dummy_nxt = 1'b0;
			return;
		end
		b = (op == minus_immediate_op) ? x : m;
		d = m_n.a - b;
		ov = (m_n.a[7] != b[7]) && (d[7] != m_n.a[7]);
		m_n.w.we = 1'b0;
		m_n.s = 1'b0;
		m_n.due = cyc + 2;
		case (op)
			skip_if_nonzero_op: m_n.s = (m != ZERO_BYTE);
			nibble_exchange_op: m_n.w = {1'b1, m[3:0], m[7:4]};
			nibble_exchange_to_working_op: m_n.a = {m[3:0], m[7:4]};
			default: begin
				m_n.f = {ov, d == 8'h00, m_n.a[3:0] >= b[3:0], m_n.a >= b, ov ^ d[7],
					d == 8'h00};
				if (op == minus_to_memory_op) m_n.w = {1'b1, d};
				else m_n.a = d;
			end
		endcase
		dummy_nxt = m_n.s;
		q.push_back(m_n);
	endtask
	// preset the accumulator, clear of any dummy cycle
	task automatic load(input logic [7:0] v);
		if (dummy_nxt) @(posedge clk_sys);
		dummy_nxt = 1'b0;
		@(posedge clk_sys);
		req.issue <= 1'b0;
		acc_load <= 1'b1;
		acc_load_data <= v;
		m_n.a = v;
	endtask
	// reset values, looked at after reset drops but before the next edge
	task automatic chk_reset();
		@(negedge clk_sys);
		cmp_note({ACC_RST, FLAGS_RST, 1'b0, MEM_WDATA_RST, 1'b0, cyc},
			{acc, flags, mem_wr, skip, cyc});
		cmp_bit(ready, 1'b1);
		m_n.a = ACC_RST;
		m_n.f = FLAGS_RST;
		m_n.w = {1'b0, MEM_WDATA_RST};
		dummy_nxt = 1'b0;
	endtask
	// stop issuing and make sure every note was met
	task automatic drain();
		@(posedge clk_sys);
		req.issue <= 1'b0;
		acc_load <= 1'b0;
		repeat (3) @(posedge clk_sys);
		cmp_bit(q.size() == 0, 1'b1);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// monitor: every done must match the oldest note, on its due cycle
	always @(negedge clk_sys) begin
		if (!rst && done === 1'b1) begin
			cmp_note(q.size() > 0 ? q.pop_front() : '0, {acc, flags, mem_wr, skip, cyc});
		end
		if (!rst && skip === 1'b1) cmp_bit(ready, 1'b0);
	end

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		chk_reset();
		// subtract corners for all three variants
		for (int i = 2; i < 5; i++) begin
			for (int j = 0; j < 5; j++) begin
				load(pa[j]);
				send(ops[i], pb[j], pb[j]);
			end
		end
		// no skip, taken skip with refused issue, then swaps back to back
		send(skip_if_nonzero_op, 8'h00, 8'h00);
		send(skip_if_nonzero_op, 8'h01, 8'h00);
		send(nibble_exchange_op, 8'h5a, 8'h00);
		send(nibble_exchange_op, 8'h3c, 8'h00);
		send(nibble_exchange_to_working_op, 8'hc3, 8'h00);
		send(op_none, 8'h11, 8'h22);
		// illegal code is a silent no-op
		send(sss_op_type'(7'h03), 8'h11, 8'h22);
		send(minus_immediate_op, 8'h00, 8'h3c);
		// random mix, refused issues follow every taken skip
		for (int i = 0; i < 400; i++) begin
			if (i % 16 == 0) load(8'($random(seed)));
			send(ops[$unsigned($random(seed)) % 7], 8'($random(seed)), 8'($random(seed)));
		end
		drain();
		// mid-run reset, then the slice must work again at once
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		chk_reset();
		send(minus_immediate_op, 8'h00, 8'h01);
		drain();
		wrap_up();
	end
endmodule
